// File: logic/dfc_consts.svh
// Numeric constants of the decimation filter and correction datapath.
// Assumes inclusion by the package and the design module only.
`ifndef DFC_CONSTS_SVH
`define DFC_CONSTS_SVH
`define DFC_OFFSET_RESET 24'h000000
`define DFC_GAIN_RESET   24'h800000
`define DFC_GAIN_FRAC    23
`define DFC_RES_MAX      24'h7fffff
`define DFC_RES_MIN      24'h800000
`define DFC_SINC3_CAP    4'ha
`define DFC_TURBO_LOG2   4'h6
`define DFC_RATIO_BASE   4'h7
`define DFC_FAST_COUNT   2'h2
`define DFC_SETTLE_MUL   3
`define DFC_SETTLE_ADD   48
`define DFC_SETTLE_BASE  1024
`define DFC_NORM_LOG2    6'h16
`endif

// File: logic/dfc_pkg.sv
// Types of the decimation filter and correction datapath.
// Assumes the constants header sits beside it.
`include "dfc_consts.svh"
package dfc_pkg;
  typedef struct packed {
    logic [23:0] offset;
    logic [23:0] gain;
  } dfc_corr_t;
  typedef enum logic [0:0] {DFC_FAST, DFC_SINC3} dfc_path_t;
endpackage

// File: logic/dfc_fifo.sv
// Small result FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module dfc_fifo
  import dfc_pkg::*;
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk, // Clock.
  input  wire logic             rst_n,    // Reset, active low.
  input  wire logic             clkEn,    // Clock enable.
  input  wire logic             inValid,  // Write request.
  output logic                  inReady,  // Room available.
  input  wire logic [WIDTH-1:0] inData,   // Write data.
  output logic                  outValid, // Data available.
  input  wire logic             outReady, // Read accept.
  output logic      [WIDTH-1:0] outData   // Head data.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  wire              doWr = inValid && inReady && clkEn;
  wire              doRd = outValid && outReady && clkEn;
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  always_ff @(posedge core_clk)
  begin
    if (doWr)
    begin
      mem[wrPtr] <= inData;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doWr)
      begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRd)
      begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule // dfc_fifo

// File: logic/dfc_decimator.sv
// Sinc3 decimator with fast-settling sinc1 path, sinc1 averager and correction.
// Assumes the modulator bit arrives from another domain with a rate strobe.
`timescale 1ns/1ps
`include "dfc_consts.svh"
// Functional notes
// - Switch to sinc3 after two conversions.
// - Ratios 64..1024 feed sinc3 straight through.
// - Ratios 2048+ use sinc3 at 1024.
// - Sinc1 averages 2,4,8 or 16 outputs.
// - Sinc3 realises cubed moving-sum response.
// - Nulls at data-rate multiples, scale with rate.
// - Restart settling on enable, mux, gain, resync.
// - Unsettled results are output, never flagged.
// - Settling cycles 3N+48 or (2+2A)*1024+48.
// - Subtract signed 24-bit offset.
// - Multiply by unsigned 1.23 gain.
// - Correction is always applied.
// - Offset resets to zero, gain to unity.
// - Fast sinc1 path runs after reset.
// - Three-bit ratio plus turbo: nine ratios.
module dfc_decimator
  import dfc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        core_clk,     // 100 MHz clock.
  input  wire logic        rst_n,        // Reset, active low.
  input  wire logic        clkEn,        // Freezes all state when low.
  input  wire logic        modBit,       // Modulator bitstream pin.
  input  wire logic        modStrobe,    // Modulator rate strobe pin.
  input  wire logic        convEnable,   // Converter enabled.
  input  wire logic        resync,       // Resynchronisation pulse.
  input  wire logic        inputChange,  // Input selection or gain changed.
  input  wire logic [2:0]  ratioSel,     // Decimation ratio field.
  input  wire logic        turbo,        // Selects ratio 64.
  input  wire dfc_corr_t   corr,         // Correction values.
  input  wire logic        corrLoad,     // Load correction values.
  output logic             resValid,     // Result available.
  input  wire logic        resReady,     // Host takes result.
  output logic [23:0]      resData,      // Corrected result.
  output dfc_path_t        path,         // Active filter path.
  output logic             settling,     // Settling interval running.
  output logic [15:0]      settleCycles  // Current settling length.
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [1:0] bitSync;
  logic [1:0] stbSync;
  logic       stbLast;
  wire        modTick = stbSync[1] && !stbLast && clkEn;
  wire        sample  = bitSync[1];
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bitSync <= '0;
      stbSync <= '0;
      stbLast <= 1'b0;
    end
    else if (clkEn)
    begin
      bitSync <= {bitSync[0], modBit};
      stbSync <= {stbSync[0], modStrobe};
      stbLast <= stbSync[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Ratio decoding.
  wire [3:0] ratioLog2 = turbo ? `DFC_TURBO_LOG2 : `DFC_RATIO_BASE + {1'b0, ratioSel};
  wire       useAvg    = ratioLog2 > `DFC_SINC3_CAP;
  wire [3:0] s3Log2    = useAvg ? `DFC_SINC3_CAP : ratioLog2;
  wire [3:0] avgLog2   = useAvg ? ratioLog2 - `DFC_SINC3_CAP : 4'h0;
  wire [15:0] s3Len    = 16'h1 << s3Log2;
  wire [15:0] avgLen   = 16'h1 << avgLog2;
  wire       restart   = !convEnable || resync || inputChange;
  ////////////////////////////////////////////////////////////////////////
  // Sinc3 integrators at modulator rate and comb at decimated rate; sinc1 fast path alongside.
  logic signed [35:0] integ [3];
  logic signed [35:0] combDly [3];
  logic [13:0]        phase;
  logic signed [15:0] fastAcc;
  wire                s3Done = modTick && (phase == 14'(s3Len - 16'h1));
  wire signed [35:0]  inVal  = sample ? 36'sd1 : -36'sd1;
  wire signed [15:0]  fastSum = fastAcc + 16'(inVal);
  logic signed [35:0] combOut [4];
  assign combOut[0] = integ[2];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : gComb
      assign combOut[gi+1] = combOut[gi] - combDly[gi];
    end
  endgenerate
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      integ   <= '{default: '0};
      combDly <= '{default: '0};
      phase   <= '0;
      fastAcc <= '0;
    end
    else if (restart && clkEn)
    begin
      integ   <= '{default: '0};
      combDly <= '{default: '0};
      phase   <= '0;
      fastAcc <= '0;
    end
    else if (modTick)
    begin
      integ[0] <= integ[0] + inVal;
      integ[1] <= integ[1] + integ[0];
      integ[2] <= integ[2] + integ[1];
      phase    <= s3Done ? '0 : phase + 14'h1;
      fastAcc  <= s3Done ? '0 : fastSum;
      if (s3Done)
      begin
        combDly <= '{combOut[0], combOut[1], combOut[2]};
      end
    end
  end
  // Normalise the filter gain so that a full-scale bitstream gives half the 24-bit range.
  // The spare bit leaves room for the offset subtraction; small ratios need a left shift.
  wire [5:0]         s3Exp    = 6'(3 * s3Log2);
  wire               s3Up     = s3Exp < `DFC_NORM_LOG2;
  wire [5:0]         s3Shift  = s3Up ? `DFC_NORM_LOG2 - s3Exp : s3Exp - `DFC_NORM_LOG2;
  wire signed [35:0] s3Norm   = s3Up ? combOut[3] <<< s3Shift : combOut[3] >>> s3Shift;
  wire signed [23:0] fastNorm = 24'(32'(fastSum) <<< (`DFC_NORM_LOG2 - 6'(s3Log2)));
  ////////////////////////////////////////////////////////////////////////
  // Path choice, sinc1 averager, settling counter.
  logic [1:0]         fastCnt;
  logic [4:0]         avgCnt;
  logic signed [28:0] avgAcc;
  logic [15:0]        settleCnt;
  logic               rawValid;
  logic signed [23:0] rawData;
  wire [4:0]  avgLast  = 5'(avgLen - 16'h1);
  wire signed [28:0] avgSum = avgAcc + 29'(s3Norm);
  wire signed [23:0] avgOut = 24'(avgSum >>> avgLog2);
  wire        avgDone  = s3Done && (!useAvg || avgCnt == avgLast);
  wire        fifoIn;
  assign path         = (fastCnt == `DFC_FAST_COUNT) ? DFC_SINC3 : DFC_FAST;
  assign settleCycles = useAvg ? 16'((2 + 2 * avgLen) * `DFC_SETTLE_BASE + `DFC_SETTLE_ADD)
                               : 16'(`DFC_SETTLE_MUL * s3Len + `DFC_SETTLE_ADD);
  assign settling     = settleCnt != settleCycles;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fastCnt   <= '0;
      avgCnt    <= '0;
      avgAcc    <= '0;
      settleCnt <= '0;
      rawValid  <= 1'b0;
      rawData   <= '0;
    end
    else if (clkEn)
    begin
      rawValid <= 1'b0;
      if (restart)
      begin
        avgCnt    <= '0;
        avgAcc    <= '0;
        settleCnt <= '0;
      end
      else
      begin
        if (settling)
        begin
          settleCnt <= settleCnt + 16'h1;
        end
        if (s3Done)
        begin
          avgCnt <= (useAvg && avgCnt != avgLast) ? avgCnt + 5'h1 : 5'h0;
          avgAcc <= (useAvg && avgCnt != avgLast) ? avgSum : 29'h0;
        end
        if (avgDone)
        begin
          rawValid <= 1'b1;
          rawData  <= (path == DFC_FAST) ? fastNorm : (useAvg ? avgOut : 24'(s3Norm));
          if (path == DFC_FAST)
          begin
            fastCnt <= fastCnt + 2'h1;
          end
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Correction: offset, gain, saturation.
  dfc_corr_t corrReg;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      corrReg <= '{offset: `DFC_OFFSET_RESET, gain: `DFC_GAIN_RESET};
    end
    else if (clkEn && corrLoad)
    begin
      corrReg <= corr;
    end
  end
  wire signed [24:0] offRes  = 25'(rawData) - 25'(signed'(corrReg.offset));
  wire signed [49:0] prod    = 50'(offRes) * 50'(signed'({1'b0, corrReg.gain}));
  wire signed [49:0] scaled  = prod >>> `DFC_GAIN_FRAC;
  wire               ovHi    = scaled > 50'(signed'(`DFC_RES_MAX));
  wire               ovLo    = scaled < 50'(signed'(`DFC_RES_MIN));
  wire [23:0]        corrOut = ovHi ? `DFC_RES_MAX : (ovLo ? `DFC_RES_MIN : scaled[23:0]);
  logic              corrValid;
  logic [23:0]       corrData;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      corrValid <= 1'b0;
      corrData  <= '0;
    end
    else if (clkEn)
    begin
      corrValid <= rawValid;
      corrData  <= corrOut;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Output buffer; a full FIFO drops the newest result.
  dfc_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) uFifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (corrValid),
    .inReady  (fifoIn),
    .inData   (corrData),
    .outValid (resValid),
    .outReady (resReady),
    .outData  (resData)
  );
endmodule // dfc_decimator

// File: verification/dfc_checker.sv
// Port assertions for the decimator.
// Assumes binding to dfc_decimator.
`timescale 1ns/1ps
module dfc_checker
  import dfc_pkg::*;
(
  input wire logic        core_clk,     // Clock.
  input wire logic        rst_n,        // Reset.
  input wire logic        clkEn,        // Enable.
  input wire logic        resync,       // Restart.
  input wire logic        turbo,        // Ratio 64.
  input wire logic [2:0]  ratioSel,     // Ratio.
  input wire logic        resValid,     // Valid.
  input wire logic        resReady,     // Ready.
  input wire logic [23:0] resData,      // Data.
  input wire dfc_path_t   path,         // Path.
  input wire logic        settling,     // Settling.
  input wire logic [15:0] settleCycles  // Length.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] cnt;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) cnt <= 16'h0;
    else if (!settling) cnt <= 16'h0;
    else if (clkEn) cnt <= cnt + 16'h1;
  property p_turbo; turbo |-> settleCycles == 16'h00f0; endproperty
  a_turbo: assert property (p_turbo) else $error("turbo length");
  property p_avg2; !turbo && ratioSel == 3'h4 |-> settleCycles == 16'h1830; endproperty
  a_avg2: assert property (p_avg2) else $error("avg2 length");
  property p_avg16; !turbo && ratioSel == 3'h7 |-> settleCycles == 16'h8830; endproperty
  a_avg16: assert property (p_avg16) else $error("avg16 length");
  property p_restart; resync |-> ##[1:4] settling; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_hold; resValid && !resReady |=> resValid && $stable(resData); endproperty
  a_hold: assert property (p_hold) else $error("result lost");
  property p_sticky; path == DFC_SINC3 |=> path == DFC_SINC3; endproperty
  a_sticky: assert property (p_sticky) else $error("path fell back");
  property p_reset; $rose(rst_n) |-> path == DFC_FAST && !resValid; endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  property p_settle; $fell(settling) |-> cnt >= settleCycles - 16'h2; endproperty
  a_settle: assert property (p_settle) else $error("settled early");
  c_sinc3: cover property (path == DFC_SINC3 && resValid);
  c_stall: cover property (resValid && !resReady);
  c_done: cover property ($fell(settling));
endmodule // dfc_checker
bind dfc_decimator dfc_checker u_chk (.core_clk, .rst_n, .clkEn, .resync, .turbo,
  .ratioSel, .resValid, .resReady, .resData, .path, .settling, .settleCycles);

// File: verification/dfc_mod_model.sv
// Modulator model: one strobe every 4 clocks.
// Assumes the same clock as the decimator.
`timescale 1ns/1ps
module dfc_mod_model (
  input  wire logic       core_clk,  // Clock.
  input  wire logic       rst_n,     // Reset.
  input  wire logic [1:0] pattern,   // 0 zeros, 1 ones, 2 alternating.
  output logic            modBit,    // Bit.
  output logic            modStrobe  // Strobe.
);
  logic [2:0] ph;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) ph <= 3'h0;
    else ph <= ph + 3'h1;
  assign modStrobe = ph[1:0] == 2'h3;
  assign modBit = pattern[1] ? ph[2] : pattern[0];
endmodule // dfc_mod_model

// File: verification/dfc_decimator_tb.sv
// Testbench for the decimator.
// Assumes the modulator model and checker.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module dfc_decimator_tb
  import dfc_pkg::*;
;
  logic core_clk = 0, rst_n = 0, clkEn = 1, convEnable = 0, resync = 0;
  logic inputChange = 0, turbo = 0, corrLoad = 0, resReady = 0;
  logic resValid, settling, modBit, modStrobe;
  logic [1:0] pat = 2'h2;
  logic [2:0] ratioSel = 3'h0;
  logic [23:0] resData, v0, d;
  logic [15:0] settleCycles;
  dfc_corr_t corr = '{24'h000000, 24'h800000};
  dfc_path_t path;
  int n_fail = 0, num_checks = 0, i;
  localparam logic [19:0] ROWS [9] = '{20'h100f0, 20'h001b0, 20'h20330, 20'h40630,
    20'h60c30, 20'h81830, 20'ha2830, 20'hc4830, 20'he8830};
  dfc_mod_model mdl (.core_clk, .rst_n, .pattern(pat), .modBit, .modStrobe);
  dfc_decimator #(.FIFO_DEPTH(4)) dut (.core_clk, .rst_n, .clkEn, .modBit, .modStrobe,
    .convEnable, .resync, .inputChange, .ratioSel, .turbo, .corr, .corrLoad, .resValid,
    .resReady, .resData, .path, .settling, .settleCycles);
  initial forever #5 core_clk = ~core_clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pop(int lim = 3000);
    int w;
    w = 0;
    while (resValid !== 1'b1 && w < lim) begin tick(1); w++; end
    if (w >= lim) begin n_fail++; stop_test(); end
    d = resData;
    resReady = 1;
    tick(1);
    resReady = 0;
    tick(1);
  endtask
  // Loads correction and drops results made before it.
  task automatic setcorr(logic [23:0] o, logic [23:0] g);
    corr = '{o, g};
    corrLoad = 1;
    tick(1);
    corrLoad = 0;
    repeat (6) pop();
  endtask
  initial begin
    tick(4);
    rst_n = 1;
    `CHK("path", DFC_FAST, path)
    `CHK("settling", 1'b1, settling)
    foreach (ROWS[k]) begin
      {ratioSel, turbo} = ROWS[k][19:16];
      tick(1);
      `CHK("settleCycles", ROWS[k][15:0], settleCycles)
    end
    $display("test ratio table done");
    // Later scenarios up to the averaging test run at ratio 64, so that one result takes 256 clocks.
    {ratioSel, turbo} = 4'h1;
    convEnable = 1;
    pop();
    `CHK("path1", DFC_FAST, path)
    pop();
    tick(2);
    `CHK("path2", DFC_SINC3, path)
    tick(1600);
    // Production stops, so the drain sees exactly what the full FIFO held.
    convEnable = 0;
    i = 0;
    while (resValid === 1'b1 && i < 8) begin pop(); i++; end
    `CHK("fifo count", 4, i)
    convEnable = 1;
    $display("test path and fifo done");
    setcorr(24'h000000, 24'h800000);
    v0 = d;
    setcorr(24'h000010, 24'h800000);
    `CHK("offset", v0 - 24'h000010, d)
    setcorr(24'h000000, 24'h000000);
    `CHK("gain zero", 24'h000000, d)
    pat = 2'h1;
    setcorr(24'h800000, 24'h800000);
    `CHK("sat high", 24'h7fffff, d)
    pat = 2'h0;
    setcorr(24'h7fffff, 24'h800000);
    `CHK("sat low", 24'h800000, d)
    $display("test correction done");
    for (int k = 0; k < 3; k++) begin
      {convEnable, inputChange, resync} = k == 0 ? 3'b101 : k == 1 ? 3'b110 : 3'b000;
      tick(1);
      {convEnable, inputChange, resync} = 3'b100;
      tick(4);
      `CHK("restart", 1'b1, settling)
      i = 0;
      while (settling === 1'b1 && i < 400) begin tick(1); i++; end
      `CHK("settled", 1'b0, settling)
      `CHK("settle time", 240 - 4, i)
    end
    $display("test restart done");
    rst_n = 0;
    tick(2);
    rst_n = 1;
    `CHK("path reset", DFC_FAST, path)
    `CHK("valid reset", 1'b0, resValid)
    // A zero bitstream gives minus half scale through the default correction.
    pop();
    `CHK("reset corr", 24'hc00000, d)
    $display("test second reset done");
    convEnable = 0;
    pat = 2'h1;
    {ratioSel, turbo} = 4'h8;
    tick(1);
    convEnable = 1;
    repeat (3) pop(9000);
    `CHK("avg result", 24'h400000, d)
    `CHK("avg path", DFC_SINC3, path)
    $display("test averaging done");
    stop_test();
  end
endmodule // dfc_decimator_tb
